// File: bench/rpsm_monitor.sv
// Checker for rpsm_top: register reads, CAN receive select, pin ownership.
// Bound to rpsm_top; sees its ports only.
`timescale 1ns/1ps
module rpsm_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Pins
  input wire logic [25:0] remappable_pin,
  input wire logic        can_receive_input,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_periph_owned
);
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire sel_wr = wr && paddr == 8'h00 && pstrb[0];
  wire lo_nz = |pwdata[4:0];
  wire hi_nz = |pwdata[12:8];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst; $rose(presetn) |-> !can_receive_input && pin_periph_owned == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_selrd; rd && paddr == 8'h00 |-> prdata[31:5] == 27'h000_0000; endproperty
  a_selrd: assert property (p_selrd) else $error("select upper bits");
  property p_maprd; rd && paddr[7:5] == 3'h1 |-> prdata[31:13] == 19'h0_0000 && prdata[7:5] == 3'h0; endproperty
  a_maprd: assert property (p_maprd) else $error("map spare bits");
  property p_tie; sel_wr && pwdata[4:0] > 5'h19 |=> ##1 !can_receive_input; endproperty
  a_tie: assert property (p_tie) else $error("not grounded");
  // Pad level is three edges old at the output: two sync stages and the mux flop
  property p_route; sel_wr && pwdata[4:0] == 5'h03 |=> ##1 can_receive_input == $past(remappable_pin[3], 3); endproperty
  a_route: assert property (p_route) else $error("pin 3 route");
  property p_lo; wr && paddr == 8'h20 && pstrb[0] |=> pin_periph_owned[0] == $past(lo_nz); endproperty
  a_lo: assert property (p_lo) else $error("pin 0 field");
  property p_hi; wr && paddr == 8'h20 && pstrb[1] |=> pin_periph_owned[1] == $past(hi_nz); endproperty
  a_hi: assert property (p_hi) else $error("pin 1 field");
  property p_own; (pin_out & ~pin_periph_owned) == 16'h0000; endproperty
  a_own: assert property (p_own) else $error("port pin driven");
endmodule : rpsm_monitor

// File: bench/rpsm_top_tb_top.sv
// Testbench for rpsm_top: register access, CAN receive select, output maps.
// Drives every port itself; no partner model.
`timescale 1ns/1ps
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module rpsm_top_tb_top;
  import rpsm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, can_receive_input;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, periph_out, r;
  logic [25:0] remappable_pin;
  logic [15:0] pin_out, pin_periph_owned;
  int          n_mismatch, comparisons;
  logic        rsp_err;
  rpsm_top u_dut (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .pstrb             (pstrb),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .remappable_pin    (remappable_pin),
    .can_receive_input (can_receive_input),
    .periph_out        (periph_out),
    .pin_out           (pin_out),
    .pin_periph_owned  (pin_periph_owned)
  );
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    rsp_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic t_reset;
    apb(0, RPSM_OFF_CAN_RX_SEL, 0);
    `CHK("sel", 32'h0000_001F, r)
    `CHK("sel err", 1'b0, rsp_err)
    for (int k = 0; k < 8; k++) begin
      apb(0, RPSM_OFF_OUT_MAP0 + 8'(4 * k), 0);
      `CHK("map", 32'h0000_0000, r)
    end
    `CHK("can rx", 1'b0, can_receive_input)
  endtask : t_reset
  task automatic t_map;
    for (int k = 0; k < 8; k++) begin
      apb(1, RPSM_OFF_OUT_MAP0 + 8'(4 * k), 32'hFFFF_E2E1);
      apb(0, RPSM_OFF_OUT_MAP0 + 8'(4 * k), 0);
      `CHK("map", 32'h0000_0201, r)
    end
    `CHK("owned", 16'hFFFF, pin_periph_owned)
    `CHK("pin out", 16'hAAAA, pin_out)
    apb(1, RPSM_OFF_OUT_MAP0, 0);
    @(posedge pclk);
    `CHK("owned", 16'hFFFC, pin_periph_owned)
  endtask : t_map
  task automatic t_sel;
    logic [4:0] codes[4] = '{5'h19, 5'h1A, 5'h1E, 5'h1F};
    apb(1, RPSM_OFF_CAN_RX_SEL, 32'hFFFF_FFE3);
    apb(0, RPSM_OFF_CAN_RX_SEL, 0);
    `CHK("sel", 32'h0000_0003, r)
    `CHK("can rx", 1'b1, can_receive_input)
    foreach (codes[i]) begin
      apb(1, RPSM_OFF_CAN_RX_SEL, {27'h000_0000, codes[i]});
      repeat (2) @(posedge pclk);
      `CHK("can rx", codes[i] == RPSM_SEL_LAST_PIN, can_receive_input)
    end
    apb(0, 8'h10, 0);
    `CHK("unmapped", 32'h0000_0000, r)
    `CHK("unmapped err", 1'b1, rsp_err)
  endtask : t_sel
  // Pad level reaches CAN receive three edges after it is driven
  task automatic t_pad;
    apb(1, RPSM_OFF_CAN_RX_SEL, 32'h0000_0003);
    for (int v = 0; v < 2; v++) begin
      remappable_pin[3] <= 1'(v);
      repeat (3) @(posedge pclk);
      `CHK("can rx hold", 1'(1 - v), can_receive_input)
      @(posedge pclk);
      `CHK("can rx pad", 1'(v), can_receive_input)
    end
  endtask : t_pad
  // Reset in mid-run must bring back the power-on values
  task automatic t_mid_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
  endtask : t_mid_reset
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    periph_out = 32'h0000_0004;
    pstrb = 4'hF;
    remappable_pin = 26'h200_0008;
    presetn = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_map();
    t_sel();
    t_pad();
    t_mid_reset();
    tally_and_finish();
  end
  // Whole run is about 150 cycles
  initial begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : rpsm_top_tb_top
bind rpsm_top rpsm_monitor u_mon (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .pstrb             (pstrb),
  .prdata            (prdata),
  .remappable_pin    (remappable_pin),
  .can_receive_input (can_receive_input),
  .pin_out           (pin_out),
  .pin_periph_owned  (pin_periph_owned)
);

// File: src/rpsm_out_if.sv
// Interface carrying the per-pin output function codes.
// Driven by the register file, read by the output routing logic.
`timescale 1ns/1ps
interface rpsm_out_if #(
  parameter int unsigned PINS = 16
);
  logic [4:0] func_code [PINS];

  modport regs (output func_code);
  modport route (input func_code);
endinterface : rpsm_out_if

// File: src/rpsm_pin_route.sv
// Output routing for one remappable pin.
// Assumes peripheral outputs are same-clock logic, index 0 unused.
`timescale 1ns/1ps
module rpsm_pin_route #(
  parameter int unsigned NUM_FUNCS = 32
) (
  // Selection
  input  wire logic [4:0]           func_code,
  input  wire logic [NUM_FUNCS-1:0] periph_out,
  // Pin side
  output logic                      pin_out,
  output logic                      pin_periph_owned
);
  import rpsm_pkg::*;

  always_comb begin
    pin_periph_owned = (func_code != RPSM_FUNC_PORT_CTRL);
    pin_out          = pin_periph_owned ? periph_out[func_code] : 1'b0;
  end
endmodule : rpsm_pin_route

// File: src/rpsm_pkg.sv
// Constants and types for the remappable pin select map.
// Assumes a 32-bit APB slave with one aligned word per register.
package rpsm_pkg;

  localparam int unsigned RPSM_ADDR_W   = 8;
  localparam int unsigned RPSM_SEL_W    = 5;
  localparam int unsigned RPSM_NUM_PINS = 26;
  localparam int unsigned RPSM_MAP_PINS = 16;
  localparam int unsigned RPSM_MAP_REGS = 8;

  // Byte offsets
  localparam logic [7:0] RPSM_OFF_CAN_RX_SEL = 8'h00;
  localparam logic [7:0] RPSM_OFF_OUT_MAP0   = 8'h20;
  localparam logic [7:0] RPSM_OFF_OUT_MAP7   = 8'h3C;
  localparam logic [7:0] RPSM_OFF_STATUS     = 8'h40;

  // Field positions
  localparam int unsigned RPSM_LO_FIELD_LSB = 0;
  localparam int unsigned RPSM_HI_FIELD_LSB = 8;

  // Reset values and selector/function codes
  localparam logic [4:0] RPSM_CAN_SEL_RESET  = 5'h1F;
  localparam logic [4:0] RPSM_FUNC_RESET     = 5'h00;
  localparam logic [4:0] RPSM_SEL_TIED_LOW   = 5'h1F;
  localparam logic [4:0] RPSM_SEL_LAST_PIN   = 5'h19;
  localparam logic [4:0] RPSM_FUNC_PORT_CTRL = 5'h00;

  typedef logic [RPSM_SEL_W-1:0] rpsm_sel_t;

endpackage : rpsm_pkg

// File: src/rpsm_top.sv
// Remappable pin select map: CAN receive input select and output maps for pins 0..15.
// Assumes an APB master on pclk; remappable pin levels come from pads and are synchronised.
// How it works
// - Bits 4-0 of the input-select register choose the pin feeding CAN receive.
// - Selector all ones ties CAN receive input to ground.
// - Codes zero to 11001 route the pin with that index.
// - Selector resets to all ones, so CAN receive starts grounded.
// - Input-select bits 15-5 ignore writes and read as zero.
// - Input-select register is disabled on variants without the CAN controller.
// - Output-map register k holds pin 2k in bits 4-0, pin 2k+1 in 12-8.
// - Output-map bits 15-13 and 7-5 ignore writes and read zero.
// - All output function fields reset to zero.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module rpsm_top #(
  parameter int unsigned NUM_FUNCS   = 32,
  parameter bit          HAS_CAN     = 1'b1
) (
  // Clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // APB slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [rpsm_pkg::RPSM_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [3:0]                       pstrb,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // Remappable pins, input side
  input  wire logic [rpsm_pkg::RPSM_NUM_PINS-1:0] remappable_pin,
  // CAN receive input to the controller
  output logic                                  can_receive_input,
  // Peripheral outputs and routed pin outputs
  input  wire logic [NUM_FUNCS-1:0]             periph_out,
  output logic [rpsm_pkg::RPSM_MAP_PINS-1:0]    pin_out,
  output logic [rpsm_pkg::RPSM_MAP_PINS-1:0]    pin_periph_owned
);
  import rpsm_pkg::*;

  // Register state
  rpsm_sel_t can_receive_pin_choice_q;
  rpsm_sel_t func_q [RPSM_MAP_PINS];
  logic [RPSM_NUM_PINS-1:0] pin_meta_q;
  logic [RPSM_NUM_PINS-1:0] pin_sync_q;
  logic                     can_rx_q;

  rpsm_out_if #(.PINS(RPSM_MAP_PINS)) out_bus ();

  // Bus decode
  logic        wr_en;
  logic        rd_en;
  logic        hit_sel;
  logic        hit_map;
  logic        hit_stat;
  logic [2:0]  map_idx;
  logic        lane0_en;
  logic        lane1_en;

  always_comb begin
    wr_en    = psel & penable & pwrite;
    rd_en    = psel & penable & ~pwrite;
    hit_sel  = (paddr == RPSM_OFF_CAN_RX_SEL) && HAS_CAN;
    hit_map  = (paddr >= RPSM_OFF_OUT_MAP0) && (paddr <= RPSM_OFF_OUT_MAP7)
               && (paddr[1:0] == 2'b00);
    hit_stat = (paddr == RPSM_OFF_STATUS);
    map_idx  = 3'(paddr[4:2]);
    lane0_en = pstrb[0];
    lane1_en = pstrb[1];
  end

  // Zero wait states; unmapped or read-only writes get an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hit_sel | hit_map | (hit_stat & ~pwrite));

  // CAN receive selector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_receive_pin_choice_q <= RPSM_CAN_SEL_RESET;
    end else if (wr_en && hit_sel && lane0_en) begin
      can_receive_pin_choice_q <= pwdata[RPSM_SEL_W-1:0];
    end
  end

  // Output function fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RPSM_MAP_PINS; i++) begin
        func_q[i] <= RPSM_FUNC_RESET;
      end
    end else if (wr_en && hit_map) begin
      if (lane0_en) begin
        func_q[{map_idx, 1'b0}] <= pwdata[RPSM_LO_FIELD_LSB +: RPSM_SEL_W];
      end
      if (lane1_en) begin
        func_q[{map_idx, 1'b1}] <= pwdata[RPSM_HI_FIELD_LSB +: RPSM_SEL_W];
      end
    end
  end

  // Pad synchroniser, two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= remappable_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // CAN receive mux; registered so the controller sees a clean level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_rx_q <= 1'b0;
    end else if (!HAS_CAN) begin
      can_rx_q <= 1'b0;
    end else if (can_receive_pin_choice_q <= RPSM_SEL_LAST_PIN) begin
      can_rx_q <= pin_sync_q[can_receive_pin_choice_q];
    end else begin
      can_rx_q <= 1'b0;
    end
  end
  assign can_receive_input = can_rx_q;

  // Read data, unimplemented bits as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en && hit_sel) begin
      prdata[RPSM_SEL_W-1:0] = can_receive_pin_choice_q;
    end else if (rd_en && hit_map) begin
      prdata[RPSM_LO_FIELD_LSB +: RPSM_SEL_W] = func_q[{map_idx, 1'b0}];
      prdata[RPSM_HI_FIELD_LSB +: RPSM_SEL_W] = func_q[{map_idx, 1'b1}];
    end else if (rd_en && hit_stat) begin
      prdata[0] = can_rx_q;
    end
  end

  // Routing through the interface
  always_comb begin
    for (int i = 0; i < RPSM_MAP_PINS; i++) begin
      out_bus.func_code[i] = func_q[i];
    end
  end

  for (genvar g = 0; g < RPSM_MAP_PINS; g++) begin : g_route
    rpsm_pin_route #(.NUM_FUNCS(NUM_FUNCS)) u_route (
      .func_code        (out_bus.func_code[g]),
      .periph_out       (periph_out),
      .pin_out          (pin_out[g]),
      .pin_periph_owned (pin_periph_owned[g])
    );
  end

endmodule : rpsm_top
